/* ssp_params.svh */
// register offsets, field positions, reset values and timing counts
// for the synchronous serial port; included by the design files.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// byte offsets on the register bus
`define SSP_OFS_CONTROL   8'h14
`define SSP_OFS_STATUS    8'h94
`define SSP_OFS_BUFFER    8'h18
`define SSP_OFS_SLAVEADR  8'h1C

// port_control fields
`define SSP_CTL_WRITE_COLLISION      7
`define SSP_CTL_OVF       6
`define SSP_CTL_EN        5
`define SSP_CTL_CKP       4

// port_status fields
`define SSP_ST_SMP        7
`define SSP_ST_CKE        6

// reset values
`define SSP_CTL_RESET     8'h00
`define SSP_ST_RESET      8'h00

// master half-period counts in aclk cycles (oscillator /4, /16, /64)
`define SSP_HALF_DIV4     6'h02
`define SSP_HALF_DIV16    6'h08
`define SSP_HALF_DIV64    6'h20

// half-ticks in one master byte, plus the trailing settle tick
`define SSP_LAST_EDGE     5'h10
`define SSP_DONE_TICK     5'h11

`endif

/* ssp_pkg.sv */
// types shared by the synchronous serial port design files
// assumes nothing of its surroundings
package ssp_pkg;

  // mode select encodings
  typedef enum logic [3:0] {
    SSP_M_DIV4   = 4'h0,
    SSP_M_DIV16  = 4'h1,
    SSP_M_DIV64  = 4'h2,
    SSP_M_TMR    = 4'h3,
    SSP_M_SLV_SS = 4'h4,
    SSP_M_SLV    = 4'h5,
    SSP_M_TW7    = 4'h6,
    SSP_M_TW10   = 4'h7,
    SSP_M_TWFW   = 4'hB,
    SSP_M_TW7I   = 4'hE,
    SSP_M_TW10I  = 4'hF
  } ssp_mode_t;

endpackage

/* ssp_sync.sv */
// three-stage input synchroniser with agreement filter
// assumes asynchronous inputs and a free-running aclk
`timescale 1ns/10ps
`default_nettype none
module ssp_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // raw and filtered level
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // stage one feeds stage two only; q moves when two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q    <= RST;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* ssp_port.sv */
// synchronous serial port: spi master/slave byte engine, two-wire
// slave receive/transmit status, and an axi4-lite register slave.
// assumes pins arrive asynchronous to aclk and timer tick is on aclk.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_port (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // timer two output pulse, same clock
  input  wire logic        timer_two_tick,
  // serial clock pin
  input  wire logic        sck_i,
  output var  logic        sck_o,
  output var  logic        sck_oe,
  // data in pin, doubles as open-drain two-wire data
  input  wire logic        sdi_i,
  output var  logic        sda_o,
  output var  logic        sda_oe,
  // data out pin
  output var  logic        sdo_o,
  output var  logic        sdo_oe,
  // slave select pin
  input  wire logic        ss_n_i
);
  logic       awv_q, wv_q, bvalid_q, rvalid_q, wstrb0_q;
  logic [7:0] awaddr_q, wdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] rdata_q;
  logic [7:0] ctl_q, buf_q, sreg_q, tx_q, addr_q;
  logic       smp_q, cke_q, dna_q, stop_q, start_q, rnw_q, ua_q, bf_q;
  logic       busy_q, sck_q, first_q, addr_ph_q, match_q, twtx_q;
  logic [5:0] cnt_q;
  logic [4:0] k_q;
  logic [3:0] bits_q;
  logic       sck_d_q, sda_d_q;
  logic       sck_s, sdi_s, ss_s;

  // pins pass four flops; ss idles high
  ssp_sync #(.W(3), .RST(3'h4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({ss_n_i, sdi_i, sck_i}),
    .q       ({ss_s, sdi_s, sck_s})
  );

  // half-period of the master clock for each divider code
  function automatic logic [5:0] half_count(input logic [3:0] m);
    unique case (m)
      4'h0:    half_count = `SSP_HALF_DIV4;
      4'h1:    half_count = `SSP_HALF_DIV16;
      default: half_count = `SSP_HALF_DIV64;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // mode decode
  wire [3:0] mode   = ctl_q[3:0];
  wire       en     = ctl_q[`SSP_CTL_EN];
  wire       clock_polarity    = ctl_q[`SSP_CTL_CKP];
  wire       is_mst = en && (mode <= 4'(ssp_pkg::SSP_M_TMR));
  wire       is_slv = en && (mode == 4'(ssp_pkg::SSP_M_SLV_SS) ||
                             mode == 4'(ssp_pkg::SSP_M_SLV));
  wire       is_tw  = en && (mode == 4'(ssp_pkg::SSP_M_TW7)  ||
                             mode == 4'(ssp_pkg::SSP_M_TW10) ||
                             mode == 4'(ssp_pkg::SSP_M_TWFW) ||
                             mode == 4'(ssp_pkg::SSP_M_TW7I) ||
                             mode == 4'(ssp_pkg::SSP_M_TW10I));
  wire       ten    = mode == 4'(ssp_pkg::SSP_M_TW10) ||
                      mode == 4'(ssp_pkg::SSP_M_TW10I);
  wire       ss_rst = en && mode == 4'(ssp_pkg::SSP_M_SLV_SS) && ss_s;

  // bus decode
  wire wr_fire = awv_q && wv_q && !bvalid_q;
  wire wr_ok   = wr_fire && wstrb0_q;
  wire wr_ctl  = wr_ok && hit(awaddr_q, `SSP_OFS_CONTROL);
  wire wr_st   = wr_ok && hit(awaddr_q, `SSP_OFS_STATUS);
  wire wr_buf  = wr_ok && hit(awaddr_q, `SSP_OFS_BUFFER);
  wire wr_adr  = wr_ok && hit(awaddr_q, `SSP_OFS_SLAVEADR);
  wire wr_map  = hit(awaddr_q, `SSP_OFS_CONTROL) ||
                 hit(awaddr_q, `SSP_OFS_STATUS) ||
                 hit(awaddr_q, `SSP_OFS_BUFFER) ||
                 hit(awaddr_q, `SSP_OFS_SLAVEADR);
  wire rd_fire = s_axi_arvalid && !rvalid_q;
  wire rd_map  = hit(s_axi_araddr, `SSP_OFS_CONTROL) ||
                 hit(s_axi_araddr, `SSP_OFS_STATUS) ||
                 hit(s_axi_araddr, `SSP_OFS_BUFFER) ||
                 hit(s_axi_araddr, `SSP_OFS_SLAVEADR);
  wire rd_buf  = rd_fire && hit(s_axi_araddr, `SSP_OFS_BUFFER);
  wire [7:0] st_v = {smp_q, cke_q, dna_q, stop_q, start_q, rnw_q, ua_q,
                     bf_q};
  wire [7:0] rd_v = hit(s_axi_araddr, `SSP_OFS_CONTROL)  ? ctl_q  :
                    hit(s_axi_araddr, `SSP_OFS_STATUS)   ? st_v   :
                    hit(s_axi_araddr, `SSP_OFS_BUFFER)   ? buf_q  :
                    hit(s_axi_araddr, `SSP_OFS_SLAVEADR) ? addr_q : 8'h00;

  // master timing: half-tick k, sample and launch points
  wire       tick   = (mode == 4'(ssp_pkg::SSP_M_TMR)) ? timer_two_tick :
                      (cnt_q == half_count(mode) - 6'h01);
  wire [4:0] kn     = k_q + 5'h01;
  wire [5:0] sph    = {1'b0, kn} - {5'h00, cke_q} - {5'h00, smp_q} - 6'h01;
  wire [5:0] lph    = {1'b0, kn} - {5'h00, cke_q};
  wire       m_step = busy_q && tick;
  wire       m_samp = m_step && !sph[5] && !sph[0] && sph <= 6'h0E;
  wire       m_lau  = m_step && !lph[5] && !lph[0] &&
                      lph >= 6'h02 && lph <= 6'h0E;
  wire       m_done = m_step && kn == `SSP_DONE_TICK;
  wire [7:0] rx_nx  = {sreg_q[6:0], sdi_s};
  wire [7:0] m_byte = m_samp ? rx_nx : sreg_q;

  // slave and two-wire clock edges seen on aclk
  wire edge_s  = sck_s ^ sck_d_q;
  wire lead    = edge_s && (sck_d_q == clock_polarity);
  wire s_samp  = is_slv && !ss_rst && (cke_q ? !lead && edge_s : lead);
  wire s_lau   = is_slv && !ss_rst && (cke_q ? lead : !lead && edge_s);
  wire s_done  = s_samp && bits_q == 4'h7;
  wire tw_rise = is_tw && sck_s && !sck_d_q;
  wire tw_fall = is_tw && !sck_s && sck_d_q;
  wire tw_sta  = is_tw && sck_s && sck_d_q && sda_d_q && !sdi_s;
  wire tw_sto  = is_tw && sck_s && sck_d_q && !sda_d_q && sdi_s;
  wire tw_rx   = tw_rise && match_q && !twtx_q;
  wire tw_byte = tw_rx && bits_q == 4'h7;
  wire tw_tx   = tw_fall && twtx_q;

  // collision: master mid-byte, slave mid-byte, two-wire transmitting
  wire busy   = busy_q || (is_slv && bits_q != 4'h0) || twtx_q;
  wire write_collision_s = wr_buf && busy;
  wire ovf_s  = (s_done && bf_q) || (tw_byte && (bf_q ||
                ctl_q[`SSP_CTL_OVF]));
  wire load   = m_done || (s_done && !bf_q) ||
                (tw_byte && !bf_q && !ctl_q[`SSP_CTL_OVF]);

  // axi write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awv_q <= 1'b0; wv_q <= 1'b0; bvalid_q <= 1'b0;
      awaddr_q <= 8'h00; wdata_q <= 8'h00; wstrb0_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (s_axi_awvalid && !awv_q) begin
        awv_q <= 1'b1; awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wv_q) begin
        wv_q <= 1'b1; wdata_q <= s_axi_wdata[7:0]; wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        awv_q <= 1'b0; wv_q <= 1'b0; bvalid_q <= 1'b1;
        bresp_q <= wr_map ? 2'h0 : 2'h2;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi read channel: one cycle to answer, unmapped reads slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0; rdata_q <= 8'h00; rresp_q <= 2'h0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1; rdata_q <= rd_v; rresp_q <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // control and status; hardware set beats a same-cycle software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= `SSP_CTL_RESET;
      {smp_q, cke_q, dna_q, stop_q, start_q, rnw_q, ua_q, bf_q}
        <= `SSP_ST_RESET;
      addr_q <= 8'h00;
    end else begin
      if (wr_ctl) ctl_q <= wdata_q;
      if (wr_st) begin
        smp_q <= wdata_q[`SSP_ST_SMP];
        cke_q <= wdata_q[`SSP_ST_CKE];
      end
      if (wr_adr) begin
        addr_q <= wdata_q;
        ua_q   <= 1'b0;
      end
      if (write_collision_s) ctl_q[`SSP_CTL_WRITE_COLLISION] <= 1'b1;
      if (ovf_s)  ctl_q[`SSP_CTL_OVF]  <= 1'b1;
      if (rd_buf) bf_q <= 1'b0;
      if (load) bf_q <= 1'b1;
      if (wr_buf && !busy && is_tw && rnw_q) bf_q <= 1'b1;
      if (tw_tx && bits_q == 4'h7) bf_q <= 1'b0;
      if (tw_sta) begin
        start_q <= 1'b1; stop_q <= 1'b0; rnw_q <= 1'b0;
      end
      if (tw_sto) begin
        stop_q <= 1'b1; start_q <= 1'b0; rnw_q <= 1'b0;
      end
      if (tw_byte) begin
        dna_q <= !addr_ph_q;
        if (addr_ph_q) begin
          rnw_q <= rx_nx[0];
          ua_q  <= ten;
        end
      end
      if (!en) begin
        start_q <= 1'b0;
        stop_q  <= 1'b0;
      end
    end
  end

  // serial engine: master, slave and two-wire share one shift path
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      buf_q <= aresetn ? buf_q : 8'h00;
      sreg_q <= 8'h00; tx_q <= 8'h00; busy_q <= 1'b0; sck_q <= 1'b0;
      cnt_q <= 6'h00; k_q <= 5'h00; bits_q <= 4'h0; first_q <= 1'b1;
      addr_ph_q <= 1'b0; match_q <= 1'b0; twtx_q <= 1'b0;
      sck_d_q <= 1'b0; sda_d_q <= 1'b1;
    end else begin
      sck_d_q <= sck_s;
      sda_d_q <= sdi_s;
      if (load) buf_q <= is_tw ? rx_nx : (m_done ? m_byte : rx_nx);
      if (wr_buf && !busy) begin
        tx_q <= wdata_q;
        if (is_mst) begin
          busy_q <= 1'b1; k_q <= 5'h00; cnt_q <= 6'h00; sck_q <= clock_polarity;
        end
        if (is_tw && rnw_q) twtx_q <= 1'b1;
      end
      // master: divider runs only while a byte moves
      if (busy_q) cnt_q <= tick ? 6'h00 : cnt_q + 6'h01;
      if (m_step) begin
        k_q <= kn;
        if (kn <= `SSP_LAST_EDGE) sck_q <= ~sck_q;
        if (m_samp) sreg_q <= rx_nx;
        if (m_lau) tx_q <= {tx_q[6:0], 1'b0};
        if (m_done) busy_q <= 1'b0;
      end
      if (!busy_q) sck_q <= clock_polarity;
      // slave
      if (s_samp) begin
        sreg_q <= rx_nx;
        bits_q <= s_done ? 4'h0 : bits_q + 4'h1;
        if (s_done) first_q <= 1'b1;
      end
      if (s_lau && (cke_q || bits_q != 4'h0)) begin
        if (first_q && cke_q) first_q <= 1'b0;
        else tx_q <= {tx_q[6:0], 1'b0};
      end
      if (ss_rst) begin
        bits_q <= 4'h0; first_q <= 1'b1;
      end
      // two-wire
      if (tw_rx) begin
        sreg_q <= rx_nx;
        bits_q <= tw_byte ? 4'h0 : bits_q + 4'h1;
        if (tw_byte && addr_ph_q) begin
          addr_ph_q <= 1'b0;
          match_q <= ten || rx_nx[7:1] == addr_q[7:1];
        end
      end
      if (tw_tx) begin
        tx_q <= {tx_q[6:0], 1'b1};
        bits_q <= bits_q == 4'h7 ? 4'h0 : bits_q + 4'h1;
        if (bits_q == 4'h7) twtx_q <= 1'b0;
      end
      if (tw_sta) begin
        bits_q <= 4'h0; addr_ph_q <= 1'b1; match_q <= 1'b1;
        twtx_q <= 1'b0;
      end
      if (tw_sto) begin
        match_q <= 1'b0; twtx_q <= 1'b0;
      end
    end
  end

  // pins: disabled port drives nothing
  assign sck_o  = is_mst && busy_q ? sck_q : (is_mst ? clock_polarity : 1'b0);
  assign sck_oe = is_mst || (is_tw && !clock_polarity);
  assign sdo_o  = tx_q[7];
  assign sdo_oe = is_mst || (is_slv && !ss_rst);
  assign sda_o  = 1'b0;
  assign sda_oe = twtx_q && !tx_q[7];
  assign s_axi_awready = !awv_q;
  assign s_axi_wready  = !wv_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h000000, rdata_q};

  a_write_collision_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_buf && busy_q |=> ctl_q[`SSP_CTL_WRITE_COLLISION])
    else $error("buffer write while busy did not flag collision");
  a_master_noovf: assert property (@(posedge aclk) disable iff (!aresetn)
    is_mst && $stable(ctl_q[3:0]) && !wr_ctl |=>
      !$rose(ctl_q[`SSP_CTL_OVF]))
    else $error("overflow raised in master mode");
  a_idle_level: assert property (@(posedge aclk) disable iff (!aresetn)
    is_mst && !busy_q |-> sck_o == clock_polarity)
    else $error("serial clock not at idle level");
  a_done_full: assert property (@(posedge aclk) disable iff (!aresetn)
    m_done |=> bf_q && buf_q == $past(m_byte))
    else $error("master byte not moved to buffer");
  a_off_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !en |=> !start_q && !stop_q)
    else $error("start or stop kept while disabled");
  a_ovf_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    s_done && bf_q |=> $stable(buf_q) && ctl_q[`SSP_CTL_OVF])
    else $error("overflow byte not discarded");
  a_ss_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    ss_rst |=> bits_q == 4'h0)
    else $error("select high did not reset transfer");
  a_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_buf && !load && !tw_fall |=> !bf_q)
    else $error("buffer read did not clear full");
  a_scl_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    is_tw && !clock_polarity |-> sck_oe && !sck_o)
    else $error("two-wire clock not held low");
  a_byte_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(busy_q) |-> busy_q [*3])
    else $error("master byte ended too early");
endmodule
`default_nettype wire

/* ssp_peer.sv */
// far-side serial device: a byte-wide shifter that answers the port,
// and that makes the link clock itself when the port is a slave.
// assumes the bench resolves pin levels and sets the clock mode.
`timescale 1ns/10ps
`default_nettype none
module ssp_peer (
  // clock mode the far side is set up for
  input  wire logic clk_pol,
  input  wire logic edge_sel,
  // resolved line levels
  input  wire logic sck_line,
  input  wire logic sdo_line,
  // lines driven by the far side
  output var  logic sck_drv,
  output var  logic sdi_drv,
  output var  logic ss_n
);
  logic [7:0] sh;
  logic [7:0] rx;

  // quiet lines, select released
  initial begin
    sck_drv = 1'b0;
    sdi_drv = 1'b1;
    ss_n = 1'b1;
    sh = 8'h00;
    rx = 8'h00;
  end

  // launch where the clock goes to pol^edge, sample on the other edge;
  // the filler is inverted so stale bits never pass for data
  always @(sck_line) begin
    if (sck_line === (clk_pol ^ edge_sel)) begin
      sdi_drv = sh[7];
      sh = {sh[6:0], ~sh[7]};
    end else if (sck_line === ~(clk_pol ^ edge_sel))
      rx = {rx[6:0], sdo_line};
  end

  // trailing-edge launch needs the first bit out before any edge
  task automatic load(input logic [7:0] b);
    rx = 8'h00;
    sh = b;
    if (!edge_sel)
      sh = {b[6:0], ~b[7]};
    sdi_drv = edge_sel ? ~sdi_drv : b[7];
  endtask

  // clock out a frame at 400 ns, clock still between frames
  task automatic send(input logic [7:0] b, input int bits, input logic sel);
    sck_drv = clk_pol;
    #100;
    load(b);
    ss_n = ~sel;
    #1013;
    repeat (2 * bits) #200 sck_drv = ~sck_drv;
    #1000 ss_n = 1'b1;
    #1000;
  endtask

  // data moves while the clock line is high: start or stop
  task automatic cond(input logic start);
    sdi_drv = start;
    #503 sck_drv = 1'b1;
    #1000 sdi_drv = ~start;
    #1000;
  endtask
endmodule
`default_nettype wire

/* sync_serial_port_tb.sv */
// self-checking bench for the serial port: bus tasks, far-side model,
// pin resolution. assumes a 20 MHz aclk and a 400 ns link clock.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module sync_serial_port_tb;
  logic        aclk, aresetn, tick, cp, ce, sck_prev;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        sck_o, sck_oe, sda_o, sda_oe, sdo_o, sdo_oe;
  logic [7:0]  awaddr, araddr, run, half_len;
  logic [31:0] wdata, rdata;
  logic [2:0]  tcnt;
  logic [1:0]  bresp, rresp;
  wire logic   sck_line, sdi_line, peer_sck, peer_sdi, peer_ss_n;
  int          failures, num_checks;
  logic [7:0]  hp [4] = '{8'h02, 8'h08, 8'h20, 8'h05};
  logic [3:0]  tw [5] = '{ssp_pkg::SSP_M_TW7, ssp_pkg::SSP_M_TW10,
    ssp_pkg::SSP_M_TWFW, ssp_pkg::SSP_M_TW7I, ssp_pkg::SSP_M_TW10I};

  always #25 aclk = ~aclk;

  // a pin follows the port while it drives, the far side otherwise
  assign sck_line = sck_oe ? sck_o : peer_sck;
  assign sdi_line = sda_oe ? sda_o : peer_sdi;

  ssp_port uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_two_tick(tick),
    .sck_i(sck_line), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .ss_n_i(peer_ss_n));

  ssp_peer peer (.clk_pol(cp), .edge_sel(ce), .sck_line(sck_line),
    .sdo_line(sdo_o), .sck_drv(peer_sck), .sdi_drv(peer_sdi),
    .ss_n(peer_ss_n));

  // timer pulse every 5 cycles; half-period meter on the clock pin
  always @(posedge aclk) begin
    tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
    tick <= (tcnt == 3'h4);
    sck_prev <= sck_o;
    run <= (sck_o !== sck_prev) ? 8'h01 : run + 8'h01;
    if (sck_o !== sck_prev)
      half_len <= run;
  end

  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask

  // ready is looked at mid-cycle, where it equals what the edge samples
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ad = ad | awready;
      wd = wd | wready;
      @(posedge aclk);
      awvalid <= ~ad;
      wvalid <= ~wd;
    end while (!(ad && wd));
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata[7:0];
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(w, e, d);
  endtask

  // polls buffer_full; the watchdog ends a hang
  task automatic wait_full();
    logic [7:0] s;
    logic [1:0] r;
    s = 8'h00;
    while (!s[0])
      rd(`SSP_OFS_STATUS, s, r);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #3000000;
    failures++;
    close_out();
  end

  initial begin
    logic [7:0] d;
    logic [1:0] r;
    {aclk, aresetn, tick, tcnt, cp, ce, awvalid, wvalid} = '0;
    {bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`SSP_OFS_CONTROL, 8'h00, "control reset");
    rc(`SSP_OFS_STATUS, 8'h00, "status reset");
    rd(8'h40, d, r);
    chk("unmapped", 8'h02, {6'h00, r});
    // every clock mode, plus late sampling, at osc/16
    for (int i = 0; i < 5; i++) begin
      cp = i[0];
      ce = i[1];
      wr(`SSP_OFS_CONTROL, 8'h00);
      chk("oe off", 8'h00, {6'h00, sck_oe, sdo_oe});
      wr(`SSP_OFS_STATUS, {i[2], ce, 6'h00});
      wr(`SSP_OFS_CONTROL, {3'b001, cp, ssp_pkg::SSP_M_DIV16});
      chk("sck idle", {7'h00, cp}, {7'h00, sck_o});
      chk("oe on", 8'h03, {6'h00, sck_oe, sdo_oe});
      peer.load(8'h3C ^ 8'(i));
      wr(`SSP_OFS_BUFFER, 8'hA5 + 8'(i));
      wait_full();
      rc(`SSP_OFS_BUFFER, 8'h3C ^ 8'(i), "rx byte");
      chk("peer byte", 8'hA5 + 8'(i), peer.rx);
      rc(`SSP_OFS_STATUS, {i[2], ce, 6'h00}, "status");
    end
    // rates, refused second write, no overflow with the buffer unread
    for (int c = 0; c < 4; c++) begin
      wr(`SSP_OFS_CONTROL, {4'h2, 4'(c)});
      wr(`SSP_OFS_BUFFER, 8'h81);
      wr(`SSP_OFS_BUFFER, 8'h7E);
      repeat (20 * int'(hp[c])) @(posedge aclk);
      chk("half period", hp[c], half_len);
      rc(`SSP_OFS_CONTROL, {4'hA, 4'(c)}, "collision");
    end
    rd(`SSP_OFS_BUFFER, d, r);
    wr(`SSP_OFS_STATUS, 8'h00);
    wr(`SSP_OFS_CONTROL, {4'h2, ssp_pkg::SSP_M_SLV_SS});
    cp = 1'b0;
    ce = 1'b0;
    peer.send(8'h96, 8, 1'b1);
    rc(`SSP_OFS_STATUS, 8'h01, "full");
    peer.send(8'h69, 8, 1'b1);
    rc(`SSP_OFS_CONTROL, 8'h64, "overflow");
    rc(`SSP_OFS_BUFFER, 8'h96, "kept byte");
    rc(`SSP_OFS_STATUS, 8'h00, "read clears");
    rc(`SSP_OFS_CONTROL, 8'h64, "ovf holds");
    wr(`SSP_OFS_CONTROL, 8'h24);
    peer.send(8'hF0, 4, 1'b1);
    peer.send(8'h5A, 8, 1'b1);
    rc(`SSP_OFS_BUFFER, 8'h5A, "after abort");
    wr(`SSP_OFS_CONTROL, 8'h25);
    peer.send(8'hC3, 8, 1'b0);
    rc(`SSP_OFS_BUFFER, 8'hC3, "no select");
    foreach (tw[k]) begin
      wr(`SSP_OFS_CONTROL, {4'h3, tw[k]});
      rc(`SSP_OFS_CONTROL, {4'h3, tw[k]}, "mode");
    end
    wr(`SSP_OFS_CONTROL, {4'h3, ssp_pkg::SSP_M_TW7});
    chk("scl free", 8'h00, {7'h00, sck_oe});
    peer.cond(1'b1);
    rc(`SSP_OFS_STATUS, 8'h08, "start");
    peer.cond(1'b0);
    rc(`SSP_OFS_STATUS, 8'h10, "stop");
    wr(`SSP_OFS_CONTROL, 8'h00);
    rc(`SSP_OFS_STATUS, 8'h00, "disabled");
    close_out();
  end
endmodule
`default_nettype wire
